// ===== src/drs_sequencer.sv
// Display reset sequencer: filters the reset pin, blanks the panel, loads NV settings, times settling.
// Assumes a 20 MHz clock, an asynchronous pin from the host and NV data valid on nv_data.
`timescale 1ns/1ps
// Contract
// - Initialisation runs while the active-low reset input is held low.
// - Low pulses under 5 us are ignored; over 10 us always reset.
// - Spike rejection keeps working inside an accepted reset pulse.
// - Settings load from non-volatile memory on every release, within 5 ms.
// - Reset while awake blanks the display, sequence no longer than 120 ms.
// - Reset while asleep just keeps the display blank.
// - After reset every setting returns to its default.
// - Release time at most 5 ms from sleep, 120 ms from awake.
module drs_sequencer #(
  parameter int unsigned LOAD_CYCLES  = drs_pkg::LOAD_CYC,
  parameter int unsigned BLANK_CYCLES = drs_pkg::BLANK_CYC,
  parameter int unsigned ACCEPT       = drs_pkg::ACCEPT_CYC,
  parameter int unsigned GLITCH       = drs_pkg::GLITCH_CYC
) (
  input  wire logic               clk,            // 20 MHz core clock
  input  wire logic               nrst,           // Power-on reset, active low
  input  wire logic               hw_reset_in_n,  // Reset pin from host, active low
  input  wire logic               sleep_in,       // Panel currently in sleep state
  input  wire drs_pkg::drs_nv_type nv_data,       // Settings held in NV memory
  output drs_pkg::drs_nv_type     settings,       // Loaded settings registers
  output logic                    in_reset,       // Device initialising
  output logic                    display_blank,  // Panel output blanked
  output logic                    blanking,       // Blanking sequence running
  output logic                    cmd_ready,      // Commands accepted
  output logic                    wake_ready      // Wake-from-sleep command allowed
);

  if (LOAD_CYCLES < 2 || BLANK_CYCLES < LOAD_CYCLES || BLANK_CYCLES >= (1 << drs_pkg::CNT_W)) begin : g_bad_timing
    $error("drs_sequencer: bad timing parameters");
  end

  drs_pkg::drs_state_type           state_r;
  logic [drs_pkg::CNT_W-1:0]        cnt_r;
  logic [drs_pkg::CNT_W-1:0]        settle_r;
  logic                             low_s;
  logic                             valid;
  logic                             release_p;

  // ------------------------------------------------------------
  // Pin filter
  // ------------------------------------------------------------
  drs_pulse_filter #(
    .ACCEPT (ACCEPT),
    .GLITCH (GLITCH)
  ) u_filter (
    .clk       (clk),
    .nrst      (nrst),
    .pin_n     (hw_reset_in_n),
    .low_s     (low_s),
    .valid_r   (valid),
    .release_p (release_p)
  );

  // ------------------------------------------------------------
  // Sequence
  // ------------------------------------------------------------
  // Blanking overlaps the pulse and stops at release or after BLANK_CYCLES; loading and settling follow the release
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_r     <= drs_pkg::ST_SETTLE;
    end else begin
      case (state_r)
        drs_pkg::ST_RUN: begin
          if (valid) begin
            state_r     <= sleep_in ? drs_pkg::ST_HOLD : drs_pkg::ST_BLANK;
          end
        end
        drs_pkg::ST_BLANK: begin
          // Release first: the pulse lasts one cycle and HOLD would never see it again
          if (release_p) state_r <= drs_pkg::ST_LOAD;
          else if (cnt_r >= drs_pkg::CNT_W'(BLANK_CYCLES - 1)) state_r <= drs_pkg::ST_HOLD;
        end
        drs_pkg::ST_HOLD: begin
          if (release_p) state_r <= drs_pkg::ST_LOAD;
        end
        drs_pkg::ST_LOAD: begin
          if (valid) state_r <= drs_pkg::ST_HOLD;
          else state_r <= drs_pkg::ST_SETTLE;
        end
        drs_pkg::ST_SETTLE: begin
          if (valid) state_r <= drs_pkg::ST_HOLD;
          else if (settle_r >= drs_pkg::CNT_W'(LOAD_CYCLES - 1)) state_r <= drs_pkg::ST_RUN;
        end
        default: state_r <= drs_pkg::ST_RUN;
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_r <= '0;
    end else if (state_r == drs_pkg::ST_BLANK) begin
      cnt_r <= cnt_r + 1'b1;
    end else begin
      cnt_r <= '0;
    end
  end

  // Time since release, saturating; drives command and wake permission
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      settle_r <= '0;
    end else if (valid || state_r == drs_pkg::ST_LOAD) begin
      settle_r <= '0;
    end else if (settle_r != drs_pkg::CNT_W'(BLANK_CYCLES)) begin
      settle_r <= settle_r + 1'b1;
    end
  end

  // Settings return to defaults during reset, then take the NV values on release
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      settings <= '{id_byte: drs_pkg::ID_RST, common_electrode_setting: drs_pkg::COMMON_ELECTRODE_SETTING_RST};
    end else if (state_r == drs_pkg::ST_LOAD) begin
      settings <= nv_data;
    end else if (valid) begin
      settings <= '{id_byte: drs_pkg::ID_RST, common_electrode_setting: drs_pkg::COMMON_ELECTRODE_SETTING_RST};
    end
  end

  assign in_reset      = state_r != drs_pkg::ST_RUN;
  assign blanking      = state_r == drs_pkg::ST_BLANK;
  assign display_blank = state_r != drs_pkg::ST_RUN;
  assign cmd_ready     = state_r == drs_pkg::ST_RUN;
  assign wake_ready    = cmd_ready && settle_r == drs_pkg::CNT_W'(BLANK_CYCLES);

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  property p_sleep_no_blank;
    @(posedge clk) disable iff (!nrst)
      state_r == drs_pkg::ST_RUN && valid && sleep_in |=> !blanking && display_blank;
  endproperty
  a_sleep_no_blank: assert property (p_sleep_no_blank) else $error("blanking ran from sleep");

  property p_awake_blank;
    @(posedge clk) disable iff (!nrst)
      state_r == drs_pkg::ST_RUN && valid && !sleep_in |=> blanking;
  endproperty
  a_awake_blank: assert property (p_awake_blank) else $error("no blanking from awake");

  property p_load_on_release;
    @(posedge clk) disable iff (!nrst)
      release_p |-> ##1 state_r == drs_pkg::ST_LOAD ##1 settings == $past(nv_data);
  endproperty
  a_load_on_release: assert property (p_load_on_release) else $error("settings not loaded at release");

  property p_default_in_reset;
    @(posedge clk) disable iff (!nrst)
      valid && state_r != drs_pkg::ST_LOAD |=> settings.common_electrode_setting == drs_pkg::COMMON_ELECTRODE_SETTING_RST;
  endproperty
  a_default_in_reset: assert property (p_default_in_reset) else $error("settings not at default");

  property p_blank_during_reset;
    @(posedge clk) disable iff (!nrst)
      valid |=> display_blank && !cmd_ready;
  endproperty
  a_blank_during_reset: assert property (p_blank_during_reset) else $error("panel live during reset");

  property p_wake_after_cmd;
    @(posedge clk) disable iff (!nrst)
      wake_ready |-> cmd_ready && settle_r >= drs_pkg::CNT_W'(LOAD_CYCLES);
  endproperty
  a_wake_after_cmd: assert property (p_wake_after_cmd) else $error("wake allowed too early");

  property p_cmd_not_early;
    @(posedge clk) disable iff (!nrst)
      $rose(cmd_ready) |-> settle_r >= drs_pkg::CNT_W'(LOAD_CYCLES - 1);
  endproperty
  a_cmd_not_early: assert property (p_cmd_not_early) else $error("commands enabled early");

  property p_accept_needs_low;
    @(posedge clk) disable iff (!nrst)
      $rose(valid) |-> $past(low_s);
  endproperty
  a_accept_needs_low: assert property (p_accept_needs_low) else $error("reset accepted with pin high");

  property p_blank_bounded;
    @(posedge clk) disable iff (!nrst)
      blanking |-> cnt_r <= drs_pkg::CNT_W'(BLANK_CYCLES - 1);
  endproperty
  a_blank_bounded: assert property (p_blank_bounded) else $error("blanking ran past its limit");

  property p_blank_ends;
    @(posedge clk) disable iff (!nrst)
      blanking && cnt_r == drs_pkg::CNT_W'(BLANK_CYCLES - 1) |=> !blanking && display_blank;
  endproperty
  a_blank_ends: assert property (p_blank_ends) else $error("blanking did not end on time");

  property p_hold_until_release;
    @(posedge clk) disable iff (!nrst)
      state_r == drs_pkg::ST_HOLD && !release_p |=> state_r == drs_pkg::ST_HOLD;
  endproperty
  a_hold_until_release: assert property (p_hold_until_release) else $error("reset left before release");

  property p_hold_blank;
    @(posedge clk) disable iff (!nrst)
      state_r == drs_pkg::ST_HOLD |-> display_blank && !blanking && !cmd_ready;
  endproperty
  a_hold_blank: assert property (p_hold_blank) else $error("hold state not simply blank");

  property p_load_then_settle;
    @(posedge clk) disable iff (!nrst)
      state_r == drs_pkg::ST_LOAD |=> state_r == drs_pkg::ST_SETTLE && settle_r == '0;
  endproperty
  a_load_then_settle: assert property (p_load_then_settle) else $error("load not followed by settling");

  property p_settle_to_run;
    @(posedge clk) disable iff (!nrst)
      state_r == drs_pkg::ST_SETTLE && !valid && settle_r == drs_pkg::CNT_W'(LOAD_CYCLES - 1) |=> cmd_ready;
  endproperty
  a_settle_to_run: assert property (p_settle_to_run) else $error("settling ran too long");

  property p_settings_stable;
    @(posedge clk) disable iff (!nrst)
      cmd_ready ##1 cmd_ready |-> $stable(settings);
  endproperty
  a_settings_stable: assert property (p_settings_stable) else $error("settings changed outside reset");

endmodule // drs_sequencer

// ===== src/drs_pkg.sv
// Package for the display reset sequencer: timing figures, cycle counts, states and carriers.
// Assumes a single 20 MHz core clock.
package drs_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned REJECT_NS     = 5000;      // Pulses shorter are rejected
  localparam int unsigned MIN_LOW_NS    = 10000;     // min_reset_low_width
  localparam int unsigned LOAD_MS       = 5;         // Settings load / sleep-in settle
  localparam int unsigned BLANK_MS      = 120;       // Blanking / sleep-out settle
  localparam int unsigned GLITCH_NS     = 1000;      // Spike width tolerated inside a pulse

  // A longest time rounds down, a least time rounds up
  localparam int unsigned REJECT_CYC = REJECT_NS / CLK_PERIOD_NS;
  localparam int unsigned ACCEPT_CYC = (MIN_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned GLITCH_CYC = GLITCH_NS / CLK_PERIOD_NS;
  localparam int unsigned LOAD_CYC   = LOAD_MS * 1000000 / CLK_PERIOD_NS;
  localparam int unsigned BLANK_CYC  = BLANK_MS * 1000000 / CLK_PERIOD_NS;

  localparam int unsigned CNT_W = 24;

  // Reset values of the loaded settings
  localparam logic [7:0] ID_RST   = 8'h00;
  localparam logic [7:0] COMMON_ELECTRODE_SETTING_RST = 8'h00;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_RUN,
    ST_HOLD,
    ST_BLANK,
    ST_LOAD,
    ST_SETTLE
  } drs_state_type;

  typedef struct packed {
    logic [7:0] id_byte;
    logic [7:0] common_electrode_setting;
  } drs_nv_type;

endpackage

// ===== src/drs_pulse_filter.sv
// Filter for the hw_reset_in_n pin: synchroniser, low-width counter and spike rejection.
// Assumes an asynchronous pin; outputs are on clk.
`timescale 1ns/1ps
module drs_pulse_filter #(
  parameter int unsigned ACCEPT = drs_pkg::ACCEPT_CYC,
  parameter int unsigned GLITCH = drs_pkg::GLITCH_CYC
) (
  input  wire logic clk,           // Core clock
  input  wire logic nrst,          // Async reset, active low
  input  wire logic pin_n,         // Raw reset pin
  output logic      low_s,         // Synchronised pin is low
  output logic      valid_r,       // Low pulse accepted, held until filtered release
  output logic      release_p      // One-cycle pulse at filtered release
);

  // Spike tolerance below two cycles would let two noisy samples in a row end a valid pulse
  if (ACCEPT <= GLITCH || GLITCH < 2 || ACCEPT >= (1 << 16)) begin : g_bad_widths
    $error("drs_pulse_filter: bad ACCEPT/GLITCH");
  end

  logic        s1_r;
  logic        s2_r;
  logic [15:0] low_cnt_r;
  logic [15:0] high_cnt_r;

  // ------------------------------------------------------------
  // Synchroniser
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s1_r <= 1'b1;
      s2_r <= 1'b1;
    end else begin
      s1_r <= pin_n;
      s2_r <= s1_r;
    end
  end
  assign low_s = ~s2_r;

  // ------------------------------------------------------------
  // Width measurement
  // ------------------------------------------------------------
  // Low time is counted only while low; a short high spike is forgiven inside a valid pulse
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      low_cnt_r <= 16'h0000;
    end else if (low_s) begin
      if (low_cnt_r != ACCEPT[15:0]) low_cnt_r <= low_cnt_r + 16'h0001;
    end else if (!valid_r || release_p) begin
      // Cleared at release too, else a pulse that follows at once finds the count saturated
      low_cnt_r <= 16'h0000;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      high_cnt_r <= 16'h0000;
    end else if (valid_r && !low_s) begin
      high_cnt_r <= high_cnt_r + 16'h0001;
    end else begin
      high_cnt_r <= 16'h0000;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      valid_r <= 1'b0;
    end else if (!valid_r && low_s && low_cnt_r == ACCEPT[15:0] - 16'h0001) begin
      valid_r <= 1'b1;
    end else if (valid_r && !low_s && high_cnt_r == GLITCH[15:0]) begin
      valid_r <= 1'b0;
    end
  end

  assign release_p = valid_r && !low_s && high_cnt_r == GLITCH[15:0];

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  property p_spike_reject;
    @(posedge clk) disable iff (!nrst)
      (!valid_r && low_s && low_cnt_r < 16'(drs_pkg::REJECT_CYC)) ##1 !low_s |-> ##1 !valid_r;
  endproperty
  a_spike_reject: assert property (p_spike_reject) else $error("short low spike was accepted");

  property p_glitch_hold;
    @(posedge clk) disable iff (!nrst)
      valid_r && low_s ##1 !low_s [*2] |-> valid_r;
  endproperty
  a_glitch_hold: assert property (p_glitch_hold) else $error("valid pulse dropped on a spike");

endmodule // drs_pulse_filter

// ===== test/drs_host_model.sv
// Host model for the display reset sequencer: drives the reset pin and gates its commands.
// Assumes the core clock of the device; all pin changes land just after a rising edge.
`timescale 1ns/1ps
module drs_host_model (
  input  wire logic clk,         // Core clock
  input  wire logic cmd_ready,   // Device accepts commands
  input  wire logic wake_ready,  // Wake command allowed
  output logic      pin_n        // Reset pin towards the device
);
  // ----------------------------------------------------------------
  // Pin driving
  // ----------------------------------------------------------------
  initial pin_n = 1'b1;

  // Holds the pin at lvl for exactly cyc cycles; no minimum low width is enforced
  task automatic drive(input logic lvl, input int cyc);
    @(posedge clk);
    pin_n <= lvl;
    repeat (cyc - 1) @(posedge clk);
  endtask

  // ----------------------------------------------------------------
  // Command gating
  // ----------------------------------------------------------------
  // No command before cmd_ready, no wake before wake_ready; bounded wait
  task automatic wait_ready(input logic wake, output int n);
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (((wake ? wake_ready : cmd_ready) !== 1'b1) && n < 4000);
  endtask
endmodule // drs_host_model

// ===== test/test_drs_sequencer.sv
// Testbench for the display reset sequencer with shortened load and blanking counts.
// Assumes the host model drives the reset pin; nv_data and sleep_in come from here.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin errors++; \
  $display("[FAIL] %s expected %0h seen %0h", nm, e, g); end end
module test_drs_sequencer;
  // Load longer than the accept width so a new pulse can land inside settling
  localparam int LOAD  = 300;
  localparam int BLANK = 600;
  localparam int ACC   = drs_pkg::ACCEPT_CYC;
  localparam int GL    = drs_pkg::GLITCH_CYC;

  logic                clk;
  logic                nrst;
  logic                sleep_in;
  logic                pin_n;
  drs_pkg::drs_nv_type nv_data;
  drs_pkg::drs_nv_type settings;
  drs_pkg::drs_nv_type exp_set;
  logic                in_reset;
  logic                display_blank;
  logic                blanking;
  logic                cmd_ready;
  logic                wake_ready;
  int                  errors;
  int                  samples_checked;
  int                  seed;
  int                  n;
  int                  n2;
  int                  w;
  int                  r;

  drs_sequencer #(.LOAD_CYCLES(LOAD), .BLANK_CYCLES(BLANK)) u_dut (
    .clk(clk), .nrst(nrst), .hw_reset_in_n(pin_n), .sleep_in(sleep_in), .nv_data(nv_data),
    .settings(settings), .in_reset(in_reset), .display_blank(display_blank), .blanking(blanking),
    .cmd_ready(cmd_ready), .wake_ready(wake_ready));

  drs_host_model u_host (.clk(clk), .cmd_ready(cmd_ready), .wake_ready(wake_ready), .pin_n(pin_n));

  // ----------------------------------------------------------------
  // Clock, closing and watchdog
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic end_of_test;
    $display("Comparisons %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Whole run is a few thousand cycles; this leaves ample margin
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    $display("[FAIL] watchdog expired");
    end_of_test();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    seed = 29;
    nrst = 1'b0;
    sleep_in = 1'b0;
    nv_data = '0;
    errors = 0;
    samples_checked = 0;
    exp_set = '0;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    // Power-on: defaults, no load, then commands allowed
    u_host.wait_ready(1'b0, n);
    `CHK("po_settings", exp_set, settings)
    `CHK("po_cmd_ready", 1'b1, cmd_ready)
    u_host.wait_ready(1'b1, n);
    // Short and mid-width lows are rejected, nothing shows at the ports
    for (int i = 0; i < 5; i++) begin
      w = (i == 4) ? 150 : 1 + ($unsigned($random(seed)) % 99);
      u_host.drive(1'b0, w);
      u_host.drive(1'b1, 6);
      #1;
      `CHK("rej_in_reset", 1'b0, in_reset)
      `CHK("rej_cmd_ready", 1'b1, cmd_ready)
    end
    // Awake, asleep, awake with a spike and a restart during settling
    for (int k = 0; k < 3; k++) begin
      r = $random(seed);
      @(posedge clk);
      nv_data <= r[15:0];
      sleep_in <= (k == 1);
      u_host.drive(1'b0, ACC + 12);
      #1;
      `CHK("acc_in_reset", 1'b1, in_reset)
      `CHK("acc_blanking", (k != 1), blanking)
      `CHK("acc_display_blank", 1'b1, display_blank)
      `CHK("acc_cmd_ready", 1'b0, cmd_ready)
      if (k == 2) begin
        u_host.drive(1'b1, GL / 2);
        #1;
        `CHK("spike_in_reset", 1'b1, in_reset)
        u_host.drive(1'b0, 20);
        u_host.drive(1'b1, GL + 8);
        #1;
        `CHK("settle_in_reset", 1'b1, in_reset)
        `CHK("mid_settings", nv_data, settings)
        r = $random(seed);
        @(posedge clk);
        nv_data <= r[15:0];
        u_host.drive(1'b0, ACC + 12);
        #1;
        `CHK("restart_in_reset", 1'b1, in_reset)
        `CHK("restart_blanking", 1'b0, blanking)
      end
      exp_set = nv_data;
      u_host.drive(1'b1, 1);
      u_host.wait_ready(1'b0, n);
      `CHK("cmd_not_early", 1'b1, (n >= LOAD))
      `CHK("cmd_not_late", 1'b1, (n <= LOAD + GL + 8))
      `CHK("loaded_settings", exp_set, settings)
      `CHK("rel_display_blank", 1'b0, display_blank)
      u_host.wait_ready(1'b1, n2);
      `CHK("wake_not_early", 1'b1, (n + n2 >= BLANK))
      `CHK("wake_not_late", 1'b1, (n + n2 <= BLANK + GL + 8))
    end
    end_of_test();
  end
endmodule // test_drs_sequencer
